// file: common/hsd_defines.vh
// Register map, reset values and encodings of the host stream splitter
`ifndef HSD_DEFINES_VH
`define HSD_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HSD_OFS_ESC_SOP 8'h00
`define HSD_OFS_ESC_CHAR 8'h04
`define HSD_OFS_POLICY 8'h08
`define HSD_OFS_CNT_SOP 8'h0C
`define HSD_OFS_CNT_DIGITS 8'h10
`define HSD_OFS_CNT_BASE 8'h14
`define HSD_OFS_CNT_RADIX 8'h18
`define HSD_OFS_STATUS 8'h1C
`define HSD_OFS_PKT_COUNT 8'h20
`define HSD_OFS_TERM_COUNT 8'h24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSD_RST_ESC_SOP 8'h1C
`define HSD_RST_ESC_CHAR 8'h10
`define HSD_RST_POLICY 1'b0
`define HSD_RST_CNT_SOP 8'h06
`define HSD_RST_CNT_DIGITS 4'h4
`define HSD_RST_CNT_BASE 8'h30
`define HSD_RST_CNT_RADIX 8'h0A

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define HSD_ST_ESC_OPEN 0
`define HSD_ST_CNT_BUSY 1
`define HSD_ST_DIGIT_ERR 2

// ----------------------------------------------------------------
// Count stage states
// ----------------------------------------------------------------
`define HSD_CS_IDLE 2'h0
`define HSD_CS_LEN 2'h1
`define HSD_CS_PAY 2'h2

`endif

// file: verilog/hsd_count_stage.v
// Count-mode stage: start byte, length field, counted payload
`timescale 1ns/1ps
`include "hsd_defines.vh"
module hsd_count_stage #(
	parameter LEN_W = 16
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire ce,
	// Incoming byte
	input wire [7:0] inByte,
	input wire inValid,
	// Settings
	input wire [7:0] sopChar,
	input wire [3:0] nDigits,
	input wire [7:0] baseChar,
	input wire [7:0] radix,
	// Packet output
	output reg [7:0] pktByte_r,
	output reg pktValid_r,
	output reg pktNew_r,
	// Pass-through output
	output reg [7:0] passByte_r,
	output reg passValid_r,
	// State
	output wire busy,
	output reg digitErr_r
);

reg [1:0] state_r;
reg [3:0] digitCnt_r;
reg [LEN_W-1:0] len_r;
reg first_r;
wire [7:0] digit = inByte - baseChar;
wire [LEN_W+7:0] lenMul = len_r * radix;
wire [LEN_W-1:0] lenNxt = lenMul[LEN_W-1:0] + {{(LEN_W-8){1'b0}}, digit};

assign busy = (state_r != `HSD_CS_IDLE);

always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		state_r <= `HSD_CS_IDLE;
		digitCnt_r <= 4'h0;
		len_r <= {LEN_W{1'b0}};
		first_r <= 1'b0;
		pktByte_r <= 8'h00;
		pktValid_r <= 1'b0;
		pktNew_r <= 1'b0;
		passByte_r <= 8'h00;
		passValid_r <= 1'b0;
		digitErr_r <= 1'b0;
	end else if (ce) begin
		pktValid_r <= 1'b0;
		passValid_r <= 1'b0;
		digitErr_r <= 1'b0;
		if (inValid) begin
			case (state_r)
			`HSD_CS_IDLE: begin
				if (inByte == sopChar) begin
					len_r <= {LEN_W{1'b0}};
					digitCnt_r <= 4'h0;
					if (nDigits != 4'h0)
						state_r <= `HSD_CS_LEN;
				end else begin
					passByte_r <= inByte;
					passValid_r <= 1'b1;
				end
			end
			`HSD_CS_LEN: begin
				// Most significant digit first; byte is stripped
				len_r <= lenNxt;
				digitCnt_r <= digitCnt_r + 4'h1;
				if (digit >= radix)
					digitErr_r <= 1'b1;
				if (digitCnt_r + 4'h1 == nDigits) begin
					first_r <= 1'b1;
					state_r <= (lenNxt == {LEN_W{1'b0}}) ?
						`HSD_CS_IDLE : `HSD_CS_PAY;
				end
			end
			`HSD_CS_PAY: begin
				// Payload passes undecoded
				pktByte_r <= inByte;
				pktValid_r <= 1'b1;
				pktNew_r <= first_r;
				first_r <= 1'b0;
				len_r <= len_r - {{(LEN_W-1){1'b0}}, 1'b1};
				if (len_r == {{(LEN_W-1){1'b0}}, 1'b1})
					state_r <= `HSD_CS_IDLE;
			end
			default: begin
				state_r <= `HSD_CS_IDLE;
			end
			endcase
		end
	end
end

endmodule // hsd_count_stage

// file: verilog/hsd_escape_stage.v
// Escape-mode stage: start byte delimits, escape byte protects data
`timescale 1ns/1ps
`include "hsd_defines.vh"
module hsd_escape_stage (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire ce,
	// Incoming byte
	input wire [7:0] inByte,
	input wire inValid,
	// Settings
	input wire [7:0] sopChar,
	input wire [7:0] escChar,
	input wire policy,
	// Packet output
	output reg [7:0] pktByte_r,
	output reg pktValid_r,
	output reg pktNew_r,
	// Terminal output
	output reg [7:0] termByte_r,
	output reg termValid_r,
	// State
	output reg opened_r
);

reg escPend_r;
reg newPend_r;
wire isSop = (inByte == sopChar);
wire isEsc = (inByte == escChar);
// With policy set only an escaped start byte is not literal; it opens a packet
wire escLit = !policy || isEsc || !isSop;

always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		escPend_r <= 1'b0;
		newPend_r <= 1'b0;
		opened_r <= 1'b0;
		pktByte_r <= 8'h00;
		pktValid_r <= 1'b0;
		pktNew_r <= 1'b0;
		termByte_r <= 8'h00;
		termValid_r <= 1'b0;
	end else if (ce) begin
		pktValid_r <= 1'b0;
		termValid_r <= 1'b0;
		if (inValid) begin
			if (escPend_r && escLit) begin
				escPend_r <= 1'b0;
				pktByte_r <= inByte;
				pktValid_r <= 1'b1;
				pktNew_r <= newPend_r;
				newPend_r <= 1'b0;
			end else if (isSop) begin
				escPend_r <= 1'b0;
				opened_r <= 1'b1;
				newPend_r <= 1'b1;
			end else if (!opened_r) begin
				termByte_r <= inByte;
				termValid_r <= 1'b1;
			end else if (isEsc) begin
				escPend_r <= 1'b1;
			end else begin
				pktByte_r <= inByte;
				pktValid_r <= 1'b1;
				pktNew_r <= newPend_r;
				newPend_r <= 1'b0;
			end
		end
	end
end

endmodule // hsd_escape_stage

// file: verilog/hsd_stream_splitter.v
// Host stream splitter top: register slave, two stages, merged outputs
`timescale 1ns/1ps
`include "hsd_defines.vh"
module hsd_stream_splitter #(
	parameter LEN_W = 16,
	parameter CNT_W = 16
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire ce,
	// Host byte stream
	input wire [7:0] hostByte,
	input wire hostValid,
	// Packet output to the router
	output reg [7:0] pktByte_r,
	output reg pktValid_r,
	output reg pktNew_r,
	// Terminal output
	output reg [7:0] termByte_r,
	output reg termValid_r,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o
);

// ----------------------------------------------------------------
// Setting registers
// ----------------------------------------------------------------
reg [7:0] escSop_r;
reg [7:0] escChar_r;
reg policy_r;
reg [7:0] cntSop_r;
reg [3:0] cntDigits_r;
reg [7:0] cntBase_r;
reg [7:0] cntRadix_r;
reg digitErrSticky_r;
reg [CNT_W-1:0] pktCount_r;
reg [CNT_W-1:0] termCount_r;

// ----------------------------------------------------------------
// Stage wiring
// ----------------------------------------------------------------
wire [7:0] cPktByte;
wire cPktValid;
wire cPktNew;
wire [7:0] cPassByte;
wire cPassValid;
wire cBusy;
wire cDigitErr;
wire [7:0] ePktByte;
wire ePktValid;
wire ePktNew;
wire [7:0] eTermByte;
wire eTermValid;
wire eOpened;
reg [7:0] cPktByteD_r;
reg cPktValidD_r;
reg cPktNewD_r;
reg [7:0] pktByte_nxt;
reg pktValid_nxt;
reg pktNew_nxt;
reg digitErrSticky_nxt;
wire [CNT_W-1:0] pktCount_nxt;
wire [CNT_W-1:0] termCount_nxt;

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire busWr = busReq && wb_we_i && wb_sel_i[0];
wire clrErr = busWr && (wb_adr_i == `HSD_OFS_STATUS) &&
	wb_dat_i[`HSD_ST_DIGIT_ERR];

// ----------------------------------------------------------------
// Write strobes
// ----------------------------------------------------------------
wire wrEscSop = busWr && (wb_adr_i == `HSD_OFS_ESC_SOP);
wire wrEscChar = busWr && (wb_adr_i == `HSD_OFS_ESC_CHAR);
wire wrPolicy = busWr && (wb_adr_i == `HSD_OFS_POLICY);
wire wrCntSop = busWr && (wb_adr_i == `HSD_OFS_CNT_SOP);
wire wrCntDigits = busWr && (wb_adr_i == `HSD_OFS_CNT_DIGITS);
wire wrCntBase = busWr && (wb_adr_i == `HSD_OFS_CNT_BASE);
wire wrCntRadix = busWr && (wb_adr_i == `HSD_OFS_CNT_RADIX);
reg [31:0] rdData;

always @* begin
	rdData = 32'h0000_0000;
	case (wb_adr_i)
	`HSD_OFS_ESC_SOP: rdData[7:0] = escSop_r;
	`HSD_OFS_ESC_CHAR: rdData[7:0] = escChar_r;
	`HSD_OFS_POLICY: rdData[0] = policy_r;
	`HSD_OFS_CNT_SOP: rdData[7:0] = cntSop_r;
	`HSD_OFS_CNT_DIGITS: rdData[3:0] = cntDigits_r;
	`HSD_OFS_CNT_BASE: rdData[7:0] = cntBase_r;
	`HSD_OFS_CNT_RADIX: rdData[7:0] = cntRadix_r;
	`HSD_OFS_STATUS: begin
		rdData[`HSD_ST_ESC_OPEN] = eOpened;
		rdData[`HSD_ST_CNT_BUSY] = cBusy;
		rdData[`HSD_ST_DIGIT_ERR] = digitErrSticky_r;
	end
	`HSD_OFS_PKT_COUNT: rdData[CNT_W-1:0] = pktCount_r;
	`HSD_OFS_TERM_COUNT: rdData[CNT_W-1:0] = termCount_r;
	default: rdData = 32'h0000_0000;
	endcase
end

// ----------------------------------------------------------------
// Bus answer
// ----------------------------------------------------------------
// One wait state; unmapped addresses answer with zero data
// Read data is caught as the request is taken and stands with ack
wire rdTake = busReq && !wb_we_i;
reg [31:0] datO_nxt;

always @* begin
	datO_nxt = wb_dat_o;
	if (rdTake)
		datO_nxt = rdData;
end

always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else if (ce) begin
		wb_ack_o <= busReq;
		wb_dat_o <= datO_nxt;
	end
end

// ----------------------------------------------------------------
// Setting writes
// ----------------------------------------------------------------
// Changing settings mid-packet takes effect on the next byte
always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		escSop_r <= `HSD_RST_ESC_SOP;
		escChar_r <= `HSD_RST_ESC_CHAR;
		policy_r <= `HSD_RST_POLICY;
		cntSop_r <= `HSD_RST_CNT_SOP;
		cntDigits_r <= `HSD_RST_CNT_DIGITS;
		cntBase_r <= `HSD_RST_CNT_BASE;
		cntRadix_r <= `HSD_RST_CNT_RADIX;
	end else if (ce) begin
		if (wrEscSop)
			escSop_r <= wb_dat_i[7:0];
		if (wrEscChar)
			escChar_r <= wb_dat_i[7:0];
		if (wrPolicy)
			policy_r <= wb_dat_i[0];
		if (wrCntSop)
			cntSop_r <= wb_dat_i[7:0];
		if (wrCntDigits)
			cntDigits_r <= wb_dat_i[3:0];
		if (wrCntBase)
			cntBase_r <= wb_dat_i[7:0];
		if (wrCntRadix)
			cntRadix_r <= wb_dat_i[7:0];
	end
end

// ----------------------------------------------------------------
// Count stage sees every host byte first
// ----------------------------------------------------------------
hsd_count_stage #(
	.LEN_W(LEN_W)
) uCount (
	.mclk(mclk),
	.arst_n(arst_n),
	.ce(ce),
	.inByte(hostByte),
	.inValid(hostValid),
	.sopChar(cntSop_r),
	.nDigits(cntDigits_r),
	.baseChar(cntBase_r),
	.radix(cntRadix_r),
	.pktByte_r(cPktByte),
	.pktValid_r(cPktValid),
	.pktNew_r(cPktNew),
	.passByte_r(cPassByte),
	.passValid_r(cPassValid),
	.busy(cBusy),
	.digitErr_r(cDigitErr)
);

// ----------------------------------------------------------------
// Escape stage scans the count stage pass-through
// ----------------------------------------------------------------
hsd_escape_stage uEscape (
	.mclk(mclk),
	.arst_n(arst_n),
	.ce(ce),
	.inByte(cPassByte),
	.inValid(cPassValid),
	.sopChar(escSop_r),
	.escChar(escChar_r),
	.policy(policy_r),
	.pktByte_r(ePktByte),
	.pktValid_r(ePktValid),
	.pktNew_r(ePktNew),
	.termByte_r(eTermByte),
	.termValid_r(eTermValid),
	.opened_r(eOpened)
);

// ----------------------------------------------------------------
// Output select
// ----------------------------------------------------------------
// Held values keep the byte lanes quiet between packet bytes
always @* begin
	pktValid_nxt = cPktValidD_r || ePktValid;
	pktByte_nxt = pktByte_r;
	pktNew_nxt = pktNew_r;
	if (cPktValidD_r) begin
		pktByte_nxt = cPktByteD_r;
		pktNew_nxt = cPktNewD_r;
	end else if (ePktValid) begin
		pktByte_nxt = ePktByte;
		pktNew_nxt = ePktNew;
	end
end

// ----------------------------------------------------------------
// Output merge
// ----------------------------------------------------------------
// Count packets are delayed one cycle so both stages share latency;
// each host byte then lands in its own output slot, no collision.
always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		cPktByteD_r <= 8'h00;
		cPktValidD_r <= 1'b0;
		cPktNewD_r <= 1'b0;
		pktByte_r <= 8'h00;
		pktValid_r <= 1'b0;
		pktNew_r <= 1'b0;
		termByte_r <= 8'h00;
		termValid_r <= 1'b0;
	end else if (ce) begin
		cPktByteD_r <= cPktByte;
		cPktValidD_r <= cPktValid;
		cPktNewD_r <= cPktNew;
		pktValid_r <= pktValid_nxt;
		pktByte_r <= pktByte_nxt;
		pktNew_r <= pktNew_nxt;
		termValid_r <= eTermValid;
		termByte_r <= eTermByte;
	end
end

// ----------------------------------------------------------------
// Status counters and flags
// ----------------------------------------------------------------
assign pktCount_nxt = pktCount_r + {{(CNT_W-1){1'b0}}, 1'b1};
assign termCount_nxt = termCount_r + {{(CNT_W-1){1'b0}}, 1'b1};

// A digit error in the same cycle as the clear wins over the clear
always @* begin
	digitErrSticky_nxt = digitErrSticky_r;
	if (clrErr)
		digitErrSticky_nxt = 1'b0;
	if (cDigitErr)
		digitErrSticky_nxt = 1'b1;
end

always @(posedge mclk or negedge arst_n) begin
	if (!arst_n) begin
		digitErrSticky_r <= 1'b0;
		pktCount_r <= {CNT_W{1'b0}};
		termCount_r <= {CNT_W{1'b0}};
	end else if (ce) begin
		digitErrSticky_r <= digitErrSticky_nxt;
		if (pktValid_r && pktNew_r)
			pktCount_r <= pktCount_nxt;
		if (termValid_r)
			termCount_r <= termCount_nxt;
	end
end

endmodule // hsd_stream_splitter

// file: tb/hsd_stream_splitter_sva.sv
// Port checker for the host stream splitter
`timescale 1ns/1ps
module hsd_stream_splitter_sva (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire ce,
	// Host stream
	input wire [7:0] hostByte,
	input wire hostValid,
	// Outputs
	input wire [7:0] pktByte_r,
	input wire pktValid_r,
	input wire pktNew_r,
	input wire [7:0] termByte_r,
	input wire termValid_r,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o
);
	// ------
	// Assertions
	// ------
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_ack_after_take: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_one_pulse: assert property (
		wb_ack_o && ce |=> !wb_ack_o) else $error("ack too long");
	chk_ack_has_cause: assert property (
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_read_narrow: assert property (
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	// Ties every output byte to the host byte three edges back
	chk_pkt_latency: assert property (
		pktValid_r |-> $past(hostValid, 3) &&
		pktByte_r == $past(hostByte, 3))
		else $error("packet byte not from host");
	chk_term_latency: assert property (
		termValid_r |-> $past(hostValid, 3) &&
		termByte_r == $past(hostByte, 3)) else $error("terminal byte wrong");
	chk_one_sink: assert property (
		!(pktValid_r && termValid_r)) else $error("byte sent to both sinks");
	chk_rst_quiet: assert property (
		!$past(arst_n) |-> !pktValid_r && !termValid_r && !wb_ack_o)
		else $error("output active after reset");

	cover property (pktValid_r && pktNew_r);
	cover property (pktValid_r && !pktNew_r);
	cover property (termValid_r);
	cover property (wb_ack_o && wb_we_i);
endmodule // hsd_stream_splitter_sva

// file: tb/hsd_host_model.sv
// Host sender model driving the byte stream
`timescale 1ns/1ps
module hsd_host_model (
	// Clock
	input wire logic mclk,
	// Byte stream
	output logic [7:0] hostByte,
	output logic hostValid
);
	initial begin
		hostByte = 8'h00;
		hostValid = 1'b0;
	end
	// Consecutive calls give back-to-back bytes
	task automatic send(input logic [7:0] b);
		@(posedge mclk);
		hostByte <= b;
		hostValid <= 1'b1;
	endtask
	// Idle line shows a changed byte so stale data cannot pass
	task automatic idle();
		@(posedge mclk);
		hostValid <= 1'b0;
		hostByte <= ~hostByte;
	endtask
endmodule // hsd_host_model

// file: tb/hsd_stream_splitter_tb.sv
// Testbench for the host stream splitter
`timescale 1ns/1ps
module hsd_stream_splitter_tb;
	logic mclk, arst_n, cyc, stb, we, ack, ce;
	logic [7:0] adr, hostByte, pktByte, termByte;
	logic [3:0] sel;
	logic [31:0] datI, datO, rd;
	logic hostValid, pktValid, pktNew, termValid;
	logic [9:0] outQ[$];
	int error_cnt = 0;
	int checked = 0;
	logic [7:0] rstVal[8] = '{8'h1C, 8'h10, 8'h00, 8'h06, 8'h04, 8'h30,
		8'h0A, 8'h00};

	hsd_stream_splitter dut_u (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.hostByte(hostByte), .hostValid(hostValid), .pktByte_r(pktByte),
		.pktValid_r(pktValid), .pktNew_r(pktNew), .termByte_r(termByte),
		.termValid_r(termValid), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
		.wb_dat_o(datO), .wb_ack_o(ack));
	hsd_host_model host_u (.mclk(mclk), .hostByte(hostByte),
		.hostValid(hostValid));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ------
	// Output capture: packet {0,new,byte}, terminal {2'b10,byte}
	// ------
	always @(posedge mclk) begin
		if (pktValid === 1'b1) outQ.push_back({1'b0, pktNew, pktByte});
		if (termValid === 1'b1) outQ.push_back({2'b10, termByte});
	end

	task automatic give_verdict();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		sel <= s;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			give_verdict();
		end
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		cmp(rd, e);
	endtask

	// Slow mode leaves a gap after every byte
	task automatic tx(input logic [7:0] b[$], input bit slow);
		foreach (b[i]) begin
			host_u.send(b[i]);
			if (slow) host_u.idle();
		end
		host_u.idle();
		repeat (8) @(posedge mclk);
	endtask

	task automatic expk(input logic [9:0] e[$]);
		foreach (e[i]) cmp(outQ.size() > 0 ? outQ.pop_front() : 'x, e[i]);
		cmp(outQ.size(), 0);
	endtask

	initial begin
		#1000000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		arst_n = 1'b0;
		{cyc, stb, we, adr, sel, datI} = '0;
		ce = 1'b1;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (rstVal[i]) rdc(8'(i * 4), {24'h0, rstVal[i]});
		rdc(8'h30, 32'h0);
		tx({8'h41, 8'h1C, 8'h41, 8'h10, 8'h1C, 8'h42, 8'h10, 8'h10,
			8'h1C, 8'h55, 8'h66}, 1'b1);
		expk({10'h241, 10'h141, 10'h01C, 10'h042, 10'h010, 10'h155,
			10'h066});
		rdc(8'h20, 32'h2);
		rdc(8'h24, 32'h1);
		rdc(8'h1C, 32'h1);
		tx({8'h06, 8'h30, 8'h30, 8'h30, 8'h32, 8'h41, 8'h06, 8'h77}, 1'b0);
		expk({10'h141, 10'h006, 10'h077});
		wr(8'h10, 32'h2);
		wr(8'h14, 32'h41);
		wr(8'h18, 32'h10);
		tx({8'h06, 8'h41, 8'h43, 8'h1C, 8'h10, 8'h5A}, 1'b0);
		expk({10'h11C, 10'h010, 10'h05A});
		wr(8'h00, 32'h2);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h1);
		wr(8'h0C, 32'h7);
		wr(8'h10, 32'h1);
		tx({8'h02, 8'h50, 8'h03, 8'h03, 8'h1C, 8'h02, 8'h51, 8'h03, 8'h02,
			8'h5B, 8'h07, 8'h42, 8'h99}, 1'b1);
		expk({10'h150, 10'h003, 10'h01C, 10'h151,
			10'h15B, 10'h199});
		ce <= 1'b0;
		tx({8'h31}, 1'b0);
		ce <= 1'b1;
		cmp(outQ.size(), 0);
		bus(1'b1, 8'h00, 32'h55, 4'h0);
		rdc(8'h00, 32'h2);
		wr(8'h18, 32'h1);
		tx({8'h07, 8'h42, 8'h88}, 1'b0);
		expk({10'h188});
		rdc(8'h1C, 32'h5);
		wr(8'h1C, 32'h4);
		rdc(8'h1C, 32'h1);
		give_verdict();
	end
endmodule // hsd_stream_splitter_tb

bind hsd_stream_splitter hsd_stream_splitter_sva chk_u (.mclk(mclk),
	.arst_n(arst_n), .ce(ce), .hostByte(hostByte), .hostValid(hostValid),
	.pktByte_r(pktByte_r), .pktValid_r(pktValid_r), .pktNew_r(pktNew_r),
	.termByte_r(termByte_r), .termValid_r(termValid_r),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
